/* rwi_pkg.sv */
package rwi_pkg;
   // ****************************************
   // Register locations
   // ****************************************
   localparam logic [12:0] ADDR_FLAGS = 13'h1FF0;
   localparam logic [12:0] ADDR_ALM_SEC = 13'h1FF2;
   localparam logic [12:0] ADDR_ALM_MIN = 13'h1FF3;
   localparam logic [12:0] ADDR_ALM_HOUR = 13'h1FF4;
   localparam logic [12:0] ADDR_ALM_DATE = 13'h1FF5;
   localparam logic [12:0] ADDR_INTERRUPTS = 13'h1FF6;
   localparam logic [12:0] ADDR_WATCHDOG = 13'h1FF7;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int WD_STEER_BIT = 7;
   localparam int WD_MULT_LSB = 2;
   localparam int IE_ALARM_BIT = 7;
   localparam int IE_PWR_BIT = 6;
   localparam int IE_BACKUP_BIT = 5;
   localparam int IE_PER_BIT = 4;
   localparam int FL_TIMEOUT_BIT = 7;
   localparam int FL_ALARM_BIT = 6;
   localparam int FL_PWR_BIT = 5;
   localparam int FL_BATT_BIT = 4;
   localparam int FL_PER_BIT = 3;
   localparam int ALM_MASK_BIT = 7;
   localparam logic [7:0] REG_RESET = 8'h00;

   // ****************************************
   // Timing; watchdog and periodic counts derived from the 32768 Hz tick, pulse widths from clk
   // ****************************************
   localparam int CLK_HZ = 100_000_000;
   localparam int OSC_HZ = 32768;
   localparam int CLK_PER_TICK = CLK_HZ / OSC_HZ;
   localparam int WD_RES_TICKS [4] = '{2048, 8192, 32768, 131072};
   localparam int TICKS_10MS = 328;
   localparam int TICKS_100MS = 3277;
   localparam int ADDR_HOLD_NS = 50;
   localparam int ADDR_HOLD_CYC = (ADDR_HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int RESET_PULSE_MS = 40;
   localparam int PWR_LEAD_US = 100;
endpackage : rwi_pkg

/* rwi_period_gen.sv */
`timescale 1ns/1ns
// Periodic event generator on oscillator ticks
module rwi_period_gen
   import rwi_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Tick and rate
   input wire logic tick,
   input wire logic [3:0] rateSel,
   // Event output
   output logic periodEvent
);
   // ****************************************
   // Interval lookup
   // ****************************************
   function automatic logic [16:0] period_ticks(input logic [3:0] code);
      logic [16:0] r;
      r = 17'h00000;
      unique case (code)
         4'h0: r = 17'h00000;
         4'h1: r = 17'(TICKS_10MS);
         4'h2: r = 17'(TICKS_100MS);
         default: r = 17'h00004 << (code - 4'h3); // 122.07us doubling
      endcase
      return r;
   endfunction : period_ticks

   logic [16:0] count; // Ticks elapsed
   logic [3:0] lastRate; // Rate seen last cycle

   // Interval counter, restarted on rate change
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         count <= 17'h00000;
         lastRate <= 4'h0;
         periodEvent <= 1'b0;
      end else begin
         lastRate <= rateSel;
         periodEvent <= 1'b0;
         if (rateSel == 4'h0 || rateSel != lastRate) begin
            count <= 17'h00000;
         end else if (tick) begin
            if (count + 17'h00001 >= period_ticks(rateSel)) begin
               count <= 17'h00000;
               periodEvent <= 1'b1;
            end else begin
               count <= count + 17'h00001;
            end
         end
      end
   end
endmodule : rwi_period_gen

/* rtc_watchdog_irq.sv */
`timescale 1ns/1ns
// Functional notes
// - timeout is multiplier times selected resolution
// - zero multiplier disables the watchdog
// - steer set: timeout pulses reset low
// - reset pulse clears watchdog register
// - steer clear: interrupt low until rewrite/powerfail
// - every timeout sets the timeout flag
// - watchdog write restarts full period
// - power failure disables the watchdog
// - events set flags; enables gate requests
// - flags read clears flags, releases interrupt
// - clear needs address held 50ns
// - rate field selects periodic interval
// - update cycle compares time with alarm
// - enabled alarm flag raises interrupt
// - mask bits select alarm repeat
// - backup mode tristates interrupt unless backup-alarm
// - powerfail sets flag, interrupt warns ahead
// - powerfail enable cleared on power-up
// - low battery at power-up sets flag
// - all interrupt enables cleared on power-up
module rtc_watchdog_irq
   import rwi_pkg::*;
#(
   parameter int RESET_PULSE_CYC = RESET_PULSE_MS * (CLK_HZ / 1000),
   parameter int PWR_LEAD_CYC = PWR_LEAD_US * (CLK_HZ / 1_000_000),
   parameter int TICK_CYC = CLK_PER_TICK
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // SRAM-style bus
   input wire logic [12:0] addr,
   input wire logic [7:0] dataIn,
   input wire logic chipSel,
   input wire logic writeStrobe,
   input wire logic readStrobe,
   output logic [7:0] dataOut,
   // Clock values at each once-per-second update
   input wire logic updatePulse,
   input wire logic [7:0] curSeconds,
   input wire logic [7:0] curMinutes,
   input wire logic [7:0] curHours,
   input wire logic [7:0] curDate,
   // Power state
   input wire logic powerFail,
   input wire logic batteryBackup,
   input wire logic batteryLow,
   // Open-drain interrupt pin, enable low drives it
   output logic intOut,
   output logic intOutEnable_n,
   // Reset output, active low
   output logic resetOut_n,
   // Deselect after the warning lead
   output logic deselect
);
   // Refuse counts that the counters cannot hold
   if (RESET_PULSE_CYC < 1 || PWR_LEAD_CYC < 1 || TICK_CYC < 1 || TICK_CYC > 8192) begin : g_param_check
      $error("Pulse widths or tick divider out of range");
   end

   // ****************************************
   // Registers and state
   // ****************************************
   logic [7:0] watchdog_control; // Watchdog register
   logic [7:0] interrupts; // Enable and rate register
   logic [7:0] alarmSec, alarmMin, alarmHour, alarmDate; // Alarm registers
   logic timeout_flag, alarm_flag, powerfail_flag, battery_low_flag, periodic_flag;
   logic [2:0] spareBits; // Unused flag bits, read back
   logic [12:0] tickDiv; // Oscillator tick divider
   logic tick; // One 32768 Hz tick
   logic [23:0] wdCount; // Watchdog ticks elapsed
   logic wdIntLatch; // Steered timeout holding interrupt
   logic [31:0] pulseCount; // Reset pulse remaining
   logic [31:0] leadCount; // Warning lead remaining
   logic [3:0] holdCount; // Cycles address stayed on flags
   logic flagsClear; // Qualified flags read
   logic pwrPrev; // Power fail last cycle
   logic powerUpDone; // Battery checked once
   logic periodEvent; // Periodic interval elapsed
   logic wdWrite, ieWrite; // Register writes
   logic timeout; // Watchdog expiry
   logic alarmHit; // Alarm match
   logic irqReq; // Enabled event pending

   localparam logic [3:0] HOLD_CYC = 4'(ADDR_HOLD_CYC);

   // Compare one alarm byte with mask
   function automatic logic alarm_match(input logic [7:0] alm, input logic [7:0] cur);
      return alm[ALM_MASK_BIT] || (alm[6:0] == cur[6:0]);
   endfunction : alarm_match

   assign wdWrite = chipSel && writeStrobe && addr == ADDR_WATCHDOG;
   assign ieWrite = chipSel && writeStrobe && addr == ADDR_INTERRUPTS;

   // ****************************************
   // Oscillator tick
   // ****************************************
   // Divide clk down to the 32768 Hz rate
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tickDiv <= 13'h0000;
         tick <= 1'b0;
      end else begin
         tick <= 1'b0;
         if (tickDiv == 13'(TICK_CYC - 1)) begin
            tickDiv <= 13'h0000;
            tick <= 1'b1;
         end else begin
            tickDiv <= tickDiv + 13'h0001;
         end
      end
   end

   // ****************************************
   // Watchdog register and counter
   // ****************************************
   // Timeout when count reaches multiplier times resolution
   assign timeout = tick && (watchdog_control[6:2] != 5'h00)
      && (wdCount + 24'h000001 >= 24'(watchdog_control[6:2]
      * WD_RES_TICKS[watchdog_control[1:0]]));

   // Watchdog register writes and clears
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         watchdog_control <= REG_RESET;
      end else if (powerFail || pulseCount != 32'h0) begin
         watchdog_control <= REG_RESET;
      end else if (wdWrite) begin
         watchdog_control <= dataIn;
      end
   end

   // Timeout counter
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wdCount <= 24'h000000;
      end else if (wdWrite || timeout || watchdog_control[6:2] == 5'h00) begin
         wdCount <= 24'h000000;
      end else if (tick) begin
         wdCount <= wdCount + 24'h000001;
      end
   end

   // Timeout steering to reset pulse or interrupt
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pulseCount <= 32'h0;
         wdIntLatch <= 1'b0;
      end else begin
         if (timeout && watchdog_control[WD_STEER_BIT]) begin
            pulseCount <= 32'(RESET_PULSE_CYC);
         end else if (pulseCount != 32'h0) begin
            pulseCount <= pulseCount - 32'h1;
         end
         if (timeout && !watchdog_control[WD_STEER_BIT]) begin
            wdIntLatch <= 1'b1;
         end else if (wdWrite || powerFail) begin
            wdIntLatch <= 1'b0;
         end
      end
   end

   // ****************************************
   // Interrupts and alarm registers
   // ****************************************
   // Enables zero after reset, enables kept through power fail
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         interrupts <= REG_RESET;
      end else if (ieWrite) begin
         interrupts <= dataIn;
      end
   end

   // Alarm registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         alarmSec <= REG_RESET;
         alarmMin <= REG_RESET;
         alarmHour <= REG_RESET;
         alarmDate <= REG_RESET;
      end else if (chipSel && writeStrobe) begin
         if (addr == ADDR_ALM_SEC) alarmSec <= dataIn;
         if (addr == ADDR_ALM_MIN) alarmMin <= dataIn;
         if (addr == ADDR_ALM_HOUR) alarmHour <= dataIn;
         if (addr == ADDR_ALM_DATE) alarmDate <= dataIn;
      end
   end

   // Masked byte compare; a set mask bit ignores that field
   assign alarmHit = updatePulse
      && alarm_match(alarmSec, curSeconds) && alarm_match(alarmMin, curMinutes)
      && alarm_match(alarmHour, curHours) && alarm_match(alarmDate, curDate);

   rwi_period_gen u_period (
      .clk(clk),
      .nrst(nrst),
      .tick(tick),
      .rateSel(interrupts[3:0]),
      .periodEvent(periodEvent)
   );

   // ****************************************
   // Flags register
   // ****************************************
   // Address must sit on flags location long enough
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         holdCount <= 4'h0;
      end else if (addr != ADDR_FLAGS) begin
         holdCount <= 4'h0;
      end else if (holdCount != HOLD_CYC) begin
         holdCount <= holdCount + 4'h1;
      end
   end

   assign flagsClear = chipSel && readStrobe && addr == ADDR_FLAGS && holdCount == HOLD_CYC;

   // Event flags; a new event wins over the clearing read
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         timeout_flag <= 1'b0;
         alarm_flag <= 1'b0;
         powerfail_flag <= 1'b0;
         periodic_flag <= 1'b0;
         spareBits <= 3'h0;
      end else begin
         if (timeout) timeout_flag <= 1'b1;
         else if (flagsClear) timeout_flag <= 1'b0;
         if (alarmHit) alarm_flag <= 1'b1;
         else if (flagsClear) alarm_flag <= 1'b0;
         if (powerFail && !pwrPrev) powerfail_flag <= 1'b1;
         else if (flagsClear) powerfail_flag <= 1'b0;
         if (periodEvent) periodic_flag <= 1'b1;
         else if (flagsClear) periodic_flag <= 1'b0;
         if (chipSel && writeStrobe && addr == ADDR_FLAGS) spareBits <= dataIn[2:0];
      end
   end

   // Battery checked once after power-up; a qualified read clears it
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         powerUpDone <= 1'b0;
         battery_low_flag <= 1'b0;
      end else if (!powerUpDone) begin
         powerUpDone <= 1'b1;
         battery_low_flag <= batteryLow;
      end else if (flagsClear) begin
         battery_low_flag <= 1'b0;
      end
   end

   // ****************************************
   // Power fail warning and deselect
   // ****************************************
   // Deselect follows the warning lead
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pwrPrev <= 1'b0;
         leadCount <= 32'h0;
         deselect <= 1'b0;
      end else begin
         pwrPrev <= powerFail;
         if (!powerFail) begin
            leadCount <= 32'h0;
            deselect <= 1'b0;
         end else if (!pwrPrev) begin
            leadCount <= 32'(PWR_LEAD_CYC);
         end else if (leadCount != 32'h0) begin
            leadCount <= leadCount - 32'h1;
         end else begin
            deselect <= 1'b1;
         end
      end
   end

   // ****************************************
   // Interrupt and reset pins
   // ****************************************
   // Any enabled flag or steered timeout requests
   assign irqReq = wdIntLatch
      || (periodic_flag && interrupts[IE_PER_BIT])
      || (alarm_flag && interrupts[IE_ALARM_BIT])
      || (powerfail_flag && interrupts[IE_PWR_BIT]);

   // Registered pin drive; backup mode only passes the alarm
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         intOutEnable_n <= 1'b1;
         resetOut_n <= 1'b1;
      end else begin
         if (batteryBackup) begin
            intOutEnable_n <= !(interrupts[IE_BACKUP_BIT] && alarm_flag
               && interrupts[IE_ALARM_BIT]);
         end else begin
            intOutEnable_n <= !irqReq;
         end
         resetOut_n <= !(timeout && watchdog_control[WD_STEER_BIT]) && pulseCount <= 32'h1;
      end
   end

   assign intOut = 1'b0;

   // ****************************************
   // Read data
   // ****************************************
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dataOut <= 8'h00;
      end else if (chipSel && readStrobe) begin
         unique case (addr)
            ADDR_FLAGS: dataOut <= {timeout_flag, alarm_flag, powerfail_flag,
               battery_low_flag, periodic_flag, spareBits};
            ADDR_ALM_SEC: dataOut <= alarmSec;
            ADDR_ALM_MIN: dataOut <= alarmMin;
            ADDR_ALM_HOUR: dataOut <= alarmHour;
            ADDR_ALM_DATE: dataOut <= alarmDate;
            ADDR_INTERRUPTS: dataOut <= interrupts;
            ADDR_WATCHDOG: dataOut <= watchdog_control;
            default: dataOut <= 8'h00;
         endcase
      end
   end
endmodule : rtc_watchdog_irq

/* rwi_host.sv */
`timescale 1ns/1ns
// Host processor model on the SRAM-style bus
module rwi_host
   import rwi_pkg::*;
(
   // Clock
   input wire logic clk,
   // Bus toward the device
   output logic [12:0] addr,
   output logic [7:0] dataIn,
   output logic chipSel,
   output logic writeStrobe,
   output logic readStrobe,
   input wire logic [7:0] dataOut
);
   // Idle bus at time zero
   initial begin
      addr = 13'h0000;
      dataIn = 8'h00;
      chipSel = 1'b0;
      writeStrobe = 1'b0;
      readStrobe = 1'b0;
   end
   // One write cycle; a write to the watchdog register services it
   task automatic wr(input logic [12:0] a, input logic [7:0] d);
      @(negedge clk);
      addr = a;
      dataIn = d;
      chipSel = 1'b1;
      writeStrobe = 1'b1;
      @(negedge clk);
      chipSel = 1'b0;
      writeStrobe = 1'b0;
      addr = ~a; // Released lines show no stale value
      dataIn = ~d;
   endtask : wr
   // Read with the address parked h cycles before the strobe
   task automatic rd(input logic [12:0] a, input int h, output logic [7:0] d);
      @(negedge clk);
      addr = a;
      chipSel = 1'b1;
      repeat (h) @(negedge clk);
      readStrobe = 1'b1;
      @(negedge clk);
      readStrobe = 1'b0;
      @(negedge clk);
      d = dataOut;
      chipSel = 1'b0;
      addr = ~a;
   endtask : rd
endmodule : rwi_host

/* rwi_irq_properties.sv */
`timescale 1ns/1ns
// Port-level checker for the watchdog and interrupt logic
module rwi_irq_checker
   import rwi_pkg::*;
#(
   parameter int RESET_PULSE_CYC = 20,
   parameter int PWR_LEAD_CYC = 10
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Bus
   input wire logic [12:0] addr,
   input wire logic [7:0] dataIn,
   input wire logic chipSel,
   input wire logic writeStrobe,
   input wire logic readStrobe,
   // Events and pins
   input wire logic updatePulse,
   input wire logic powerFail,
   input wire logic batteryBackup,
   input wire logic intOut,
   input wire logic intOutEnable_n,
   input wire logic resetOut_n,
   input wire logic deselect
);
   localparam int DL = PWR_LEAD_CYC;
   localparam int DH = PWR_LEAD_CYC + 2;
   logic [7:0] ieCopy; // Shadow of the enables
   int holdCnt; // Cycles address rested on flags
   int lowCnt; // Length of reset pulse so far
   wire logic rdFlags = chipSel && readStrobe && addr == ADDR_FLAGS;
   // Track enable writes
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) ieCopy <= REG_RESET;
      else if (chipSel && writeStrobe && addr == ADDR_INTERRUPTS) ieCopy <= dataIn;
   end
   // Count address hold on flags
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) holdCnt <= 0;
      else holdCnt <= (addr == ADDR_FLAGS) ? holdCnt + 1 : 0;
   end
   // Count reset pulse length
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) lowCnt <= 0;
      else lowCnt <= resetOut_n ? 0 : lowCnt + 1;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence s_long_read; rdFlags && holdCnt >= 5 && !updatePulse && !powerFail; endsequence
   sequence s_quiet; (batteryBackup && !ieCopy[IE_BACKUP_BIT])[*2]; endsequence
   property p_rd_clear; s_long_read |-> ##2 intOutEnable_n; endproperty
   property p_short_hold; rdFlags && holdCnt == 0 && !intOutEnable_n |-> ##2 !intOutEnable_n; endproperty
   property p_int_val; intOut == 1'b0; endproperty
   property p_rst_pulse; $rose(resetOut_n) |-> lowCnt == RESET_PULSE_CYC; endproperty
   property p_desel_early; $rose(powerFail) |-> !deselect[*5]; endproperty
   property p_desel_on; $rose(powerFail) |-> ##[DL:DH] deselect; endproperty
   property p_pf_irq; $rose(powerFail) && ieCopy[IE_PWR_BIT] |-> ##[1:3] !intOutEnable_n; endproperty
   property p_backup_quiet; s_quiet |-> intOutEnable_n; endproperty
   a_rd_clear: assert property (p_rd_clear) else $error("flags read left pin low");
   a_short_hold: assert property (p_short_hold) else $error("short hold cleared flags");
   a_int_val: assert property (p_int_val) else $error("pin value not low");
   a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse length wrong");
   a_desel_early: assert property (p_desel_early) else $error("deselect too early");
   a_desel_on: assert property (p_desel_on) else $error("deselect missing");
   a_pf_irq: assert property (p_pf_irq) else $error("power-fail request missing");
   a_backup_quiet: assert property (p_backup_quiet) else $error("pin driven in backup");
endmodule : rwi_irq_checker
bind rtc_watchdog_irq rwi_irq_checker #(.RESET_PULSE_CYC(RESET_PULSE_CYC), .PWR_LEAD_CYC(PWR_LEAD_CYC))
   i_rwi_irq_checker (.clk(clk), .nrst(nrst), .addr(addr), .dataIn(dataIn), .chipSel(chipSel),
   .writeStrobe(writeStrobe), .readStrobe(readStrobe), .updatePulse(updatePulse), .powerFail(powerFail),
   .batteryBackup(batteryBackup), .intOut(intOut), .intOutEnable_n(intOutEnable_n), .resetOut_n(resetOut_n),
   .deselect(deselect));

/* tb.sv */
`timescale 1ns/1ns
// Self-checking bench for the watchdog and interrupt logic
module tb
   import rwi_pkg::*;
;
   logic clk, nrst, chipSel, writeStrobe, readStrobe, updatePulse;
   logic powerFail, batteryBackup, batteryLow, intOut, intOutEnable_n, resetOut_n, deselect;
   logic [12:0] addr;
   logic [7:0] dataIn, dataOut, curSeconds, curMinutes, curHours, curDate, d;
   int failures = 0;
   int totalChecks = 0;
   int cycles = 0;
   rwi_host i_rwi_host (.clk(clk), .addr(addr), .dataIn(dataIn), .chipSel(chipSel),
      .writeStrobe(writeStrobe), .readStrobe(readStrobe), .dataOut(dataOut));
   rtc_watchdog_irq #(.RESET_PULSE_CYC(20), .PWR_LEAD_CYC(10), .TICK_CYC(1))
      i_rtc_watchdog_irq (.clk(clk), .nrst(nrst),
      .addr(addr), .dataIn(dataIn), .chipSel(chipSel), .writeStrobe(writeStrobe), .readStrobe(readStrobe),
      .dataOut(dataOut), .updatePulse(updatePulse), .curSeconds(curSeconds), .curMinutes(curMinutes),
      .curHours(curHours), .curDate(curDate), .powerFail(powerFail), .batteryBackup(batteryBackup),
      .batteryLow(batteryLow), .intOut(intOut), .intOutEnable_n(intOutEnable_n), .resetOut_n(resetOut_n),
      .deselect(deselect));
   // Clock generator
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Byte comparison
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      totalChecks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // Verdict and end of run
   task automatic tally_and_finish;
      $display("Checks %0d mismatches %0d", totalChecks, failures);
      if (failures == 0 && totalChecks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : tally_and_finish
   // One clock update with the given seconds
   task automatic upd(input logic [7:0] s);
      @(negedge clk);
      curSeconds = s;
      updatePulse = 1'b1;
      @(negedge clk);
      updatePulse = 1'b0;
      repeat (2) @(negedge clk);
   endtask : upd
   // Bounded wait for the pin to be pulled low
   task automatic wait_irq(input int n);
      for (int i = 0; i < n && intOutEnable_n !== 1'b0; i++) @(negedge clk);
   endtask : wait_irq
   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 80000) begin
         failures++;
         tally_and_finish();
      end
   end
   // Main sequence
   initial begin
      {nrst, updatePulse, powerFail, batteryBackup} = 4'h0;
      batteryLow = 1'b1;
      curSeconds = 8'h00;
      curMinutes = 8'h15;
      curHours = 8'h08;
      curDate = 8'h21;
      repeat (6) @(negedge clk);
      nrst = 1'b1;
      repeat (2) @(negedge clk);
      batteryLow = 1'b0;
      i_rwi_host.rd(ADDR_INTERRUPTS, 0, d);
      chk("enables", 8'h00, d);
      chk("pins", 8'h03, {5'h00, intOut, intOutEnable_n, resetOut_n});
      i_rwi_host.wr(ADDR_WATCHDOG, 8'h8E);
      i_rwi_host.rd(ADDR_WATCHDOG, 0, d);
      chk("watchdog", 8'h8E, d);
      i_rwi_host.wr(13'h0100, 8'h5A);
      i_rwi_host.rd(13'h0100, 0, d);
      chk("unmapped", 8'h00, d);
      // Alarm on seconds only
      i_rwi_host.wr(ADDR_ALM_SEC, 8'h30);
      for (int a = 3; a < 6; a++) i_rwi_host.wr(13'h1FF0 + 13'(a), 8'h80);
      i_rwi_host.wr(ADDR_INTERRUPTS, 8'h80);
      upd(8'h29);
      chk("mismatch pin", 8'h01, intOutEnable_n);
      upd(8'h30);
      chk("alarm pin", 8'h00, intOutEnable_n);
      i_rwi_host.rd(ADDR_FLAGS, 0, d);
      chk("flags", 8'h50, d);
      chk("short hold pin", 8'h00, intOutEnable_n);
      i_rwi_host.rd(ADDR_FLAGS, 6, d);
      chk("flags kept", 8'h50, d);
      chk("cleared pin", 8'h01, intOutEnable_n);
      i_rwi_host.rd(ADDR_FLAGS, 6, d);
      chk("flags cleared", 8'h00, d);
      // Alarm on full date match
      i_rwi_host.wr(ADDR_ALM_MIN, 8'h15);
      i_rwi_host.wr(ADDR_ALM_HOUR, 8'h08);
      i_rwi_host.wr(ADDR_ALM_DATE, 8'h22);
      upd(8'h30);
      chk("date mismatch", 8'h01, intOutEnable_n);
      i_rwi_host.wr(ADDR_ALM_DATE, 8'h21);
      upd(8'h30);
      chk("date match", 8'h00, intOutEnable_n);
      i_rwi_host.rd(ADDR_FLAGS, 6, d);
      // Periodic events, enabled then polled, then off
      i_rwi_host.wr(ADDR_INTERRUPTS, 8'h11);
      repeat (300) @(negedge clk);
      chk("periodic early", 8'h01, intOutEnable_n);
      wait_irq(60);
      chk("periodic pin", 8'h00, intOutEnable_n);
      i_rwi_host.wr(ADDR_INTERRUPTS, 8'h03);
      i_rwi_host.rd(ADDR_FLAGS, 6, d);
      repeat (13000) @(negedge clk);
      chk("polled pin", 8'h01, intOutEnable_n);
      i_rwi_host.rd(ADDR_FLAGS, 6, d);
      chk("periodic flag", 8'h08, d);
      i_rwi_host.wr(ADDR_INTERRUPTS, 8'h00);
      i_rwi_host.rd(ADDR_FLAGS, 6, d);
      repeat (13000) @(negedge clk);
      i_rwi_host.rd(ADDR_FLAGS, 6, d);
      chk("rate off", 8'h00, d);
      // Watchdog on one-cycle ticks, steered to the interrupt pin
      i_rwi_host.wr(ADDR_WATCHDOG, 8'h04);
      repeat (1500) @(negedge clk);
      i_rwi_host.wr(ADDR_WATCHDOG, 8'h04);
      repeat (2040) @(negedge clk);
      chk("wd serviced", 8'h01, intOutEnable_n);
      wait_irq(20);
      chk("wd irq", 8'h00, intOutEnable_n);
      i_rwi_host.wr(ADDR_WATCHDOG, 8'h00);
      @(negedge clk);
      chk("wd irq released", 8'h01, intOutEnable_n);
      repeat (2100) @(negedge clk);
      chk("wd disabled", 8'h01, intOutEnable_n);
      i_rwi_host.rd(ADDR_FLAGS, 6, d);
      chk("wd flag", 8'h80, d);
      // Watchdog steered to the reset pulse
      i_rwi_host.wr(ADDR_WATCHDOG, 8'h84);
      for (int i = 0; i < 2100 && resetOut_n !== 1'b0; i++) @(negedge clk);
      chk("wd reset", 8'h00, resetOut_n);
      i_rwi_host.rd(ADDR_WATCHDOG, 0, d);
      chk("wd cleared", 8'h00, d);
      chk("reset held", 8'h00, resetOut_n);
      repeat (20) @(negedge clk);
      chk("reset end", 8'h01, resetOut_n);
      i_rwi_host.rd(ADDR_FLAGS, 6, d);
      chk("wd reset flag", 8'h80, d);
      // Power failure
      i_rwi_host.wr(ADDR_WATCHDOG, 8'h0E);
      i_rwi_host.wr(ADDR_INTERRUPTS, 8'h40);
      powerFail = 1'b1;
      repeat (3) @(negedge clk);
      chk("pf pin", 8'h00, intOutEnable_n);
      repeat (12) @(negedge clk);
      chk("deselect", 8'h01, deselect);
      powerFail = 1'b0;
      repeat (3) @(negedge clk);
      i_rwi_host.rd(ADDR_WATCHDOG, 0, d);
      chk("wd after pf", 8'h00, d);
      i_rwi_host.rd(ADDR_FLAGS, 6, d);
      chk("pf flag", 8'h20, d);
      i_rwi_host.wr(ADDR_WATCHDOG, 8'h0E);
      // Battery backup alarm
      i_rwi_host.wr(ADDR_INTERRUPTS, 8'h80);
      batteryBackup = 1'b1;
      upd(8'h30);
      chk("backup quiet", 8'h01, intOutEnable_n);
      i_rwi_host.rd(ADDR_FLAGS, 6, d);
      chk("backup flag", 8'h40, d);
      i_rwi_host.wr(ADDR_INTERRUPTS, 8'hA0);
      upd(8'h30);
      chk("backup alarm", 8'h00, intOutEnable_n);
      tally_and_finish();
   end
endmodule : tb
